/* rtl/fifo_flags_defines.vh */
// constants for the dual-clock fifo flag, mailbox and parity block
`ifndef FIFO_FLAGS_DEFINES_VH
`define FIFO_FLAGS_DEFINES_VH

`define FIFO_DATA_W        36
`define FIFO_ADDR_W        6
`define FIFO_PTR_W         7
`define FIFO_DEPTH         7'h40
`define FIFO_PTR_RST       7'h00
`define FIFO_BYTE_W        9
`define OFFSET_SEL_HH      7'h10
`define OFFSET_SEL_HL      7'h0C
`define OFFSET_SEL_LH      7'h08
`define OFFSET_SEL_LL      7'h04
`define OFFSET_RST         7'h04
`define FULL_REL_RST       2'h0
`define DATA_RST           36'h000000000

`endif

/* rtl/fifo_flags_mailbox.v */
// 64 x 36 dual-port fifo with synchronized flags, mailboxes and parity check
`timescale 1ns/10ps
`default_nettype none
`include "fifo_flags_defines.vh"

module fifo_flags_mailbox
#(
    parameter DATA_W = `FIFO_DATA_W,
    parameter ADDR_W = `FIFO_ADDR_W
)
(
    input  wire              SYS_CLK_IN,
    input  wire              RESETN_IN,
    input  wire              WRITE_SIDE_CLOCK_IN,
    input  wire              READ_SIDE_CLOCK_IN,
    input  wire              OFFSET_SEL_LO_IN,
    input  wire              OFFSET_SEL_HI_IN,
    input  wire              PARITY_ODD_SEL_IN,
    input  wire              PORTA_SEL_N_IN,
    input  wire              PORTA_DIR_WRITE_IN,
    input  wire              PORTA_XFER_EN_IN,
    input  wire              PORTA_MAIL_SEL_IN,
    input  wire              PORTA_PARITY_GEN_IN,
    input  wire [DATA_W-1:0] PORTA_DATA_IN,
    output wire [DATA_W-1:0] PORTA_DATA_OUT,
    output wire              PORTA_DATA_OE_OUT,
    output wire              PORTA_PARITY_ERR_N_OUT,
    input  wire              PORTB_SEL_N_IN,
    input  wire              PORTB_DIR_WRITE_IN,
    input  wire              PORTB_XFER_EN_IN,
    input  wire              PORTB_MAIL_SEL_IN,
    input  wire              PORTB_PARITY_GEN_IN,
    input  wire [DATA_W-1:0] PORTB_DATA_IN,
    output wire [DATA_W-1:0] PORTB_DATA_OUT,
    output wire              PORTB_DATA_OE_OUT,
    output wire              PORTB_PARITY_ERR_N_OUT,
    output wire              IN_FULL_N_OUT,
    output wire              NEAR_FULL_N_OUT,
    output wire              OUT_EMPTY_N_OUT,
    output wire              NEAR_EMPTY_N_OUT,
    output wire              MAIL_IN_FLAG_N_OUT,
    output wire              MAIL_OUT_FLAG_N_OUT
);

    // one when any of the four nine-bit bytes fails under the chosen sense
    function bus_fails;
        input [DATA_W-1:0] bus;
        input              odd_sel;
        integer            k;
        begin
            bus_fails = 1'b0;
            for (k = 0; k < 4; k = k + 1)
            begin
                bus_fails = bus_fails | ((^bus[k*`FIFO_BYTE_W +: `FIFO_BYTE_W]) ^ odd_sel);
            end
        end
    endfunction

    reg  [DATA_W-1:0]     mem [0:(1<<ADDR_W)-1];
    reg                   wclk_prev_r;
    reg                   rclk_prev_r;
    reg                   rstn_prev_r;
    reg  [`FIFO_PTR_W-1:0] wptr_r;
    reg  [`FIFO_PTR_W-1:0] rptr_r;
    reg  [`FIFO_PTR_W-1:0] wptr_at_rd_r;
    reg  [`FIFO_PTR_W-1:0] rptr_at_wr_r;
    reg  [`FIFO_PTR_W-1:0] offset_r;
    reg  [1:0]            full_rel_r;
    reg                   in_full_n_r;
    reg                   near_full_n_r;
    reg                   out_empty_n_r;
    reg                   near_empty_n_r;
    reg                   mail_in_flag_n_r;
    reg                   mail_out_flag_n_r;
    reg  [DATA_W-1:0]     mail_in_r;
    reg  [DATA_W-1:0]     mail_out_r;
    reg  [DATA_W-1:0]     out_reg_r;
    reg  [1:0]            full_rel_nxt;
    reg                   in_full_n_nxt;
    reg                   near_full_n_nxt;
    reg                   out_empty_n_nxt;
    reg                   near_empty_n_nxt;
    reg                   mail_in_flag_n_nxt;
    reg                   mail_out_flag_n_nxt;
    reg  [DATA_W-1:0]     mail_in_nxt;
    reg  [DATA_W-1:0]     mail_out_nxt;
    reg  [DATA_W-1:0]     out_reg_nxt;

    wire                  wr_edge;
    wire                  rd_edge;
    wire                  a_write;
    wire                  a_read;
    wire                  b_write;
    wire                  b_read;
    wire                  fifo_wr;
    wire                  fifo_rd;
    wire                  mail_in_wr;
    wire                  mail_out_wr;
    wire [`FIFO_PTR_W-1:0] wptr_nxt;
    wire [`FIFO_PTR_W-1:0] rptr_nxt;
    wire [`FIFO_PTR_W-1:0] fill_wr_side;
    wire [`FIFO_PTR_W-1:0] fill_rd_side;
    wire [`FIFO_PTR_W-1:0] full_mark;

    // port clocks are sampled levels; an edge is a low-to-high between samples
    assign wr_edge = WRITE_SIDE_CLOCK_IN & ~wclk_prev_r;
    assign rd_edge = READ_SIDE_CLOCK_IN & ~rclk_prev_r;

    assign a_write = ~PORTA_SEL_N_IN & PORTA_DIR_WRITE_IN & PORTA_XFER_EN_IN;
    assign a_read  = ~PORTA_SEL_N_IN & ~PORTA_DIR_WRITE_IN & PORTA_XFER_EN_IN;
    assign b_write = ~PORTB_SEL_N_IN & PORTB_DIR_WRITE_IN & PORTB_XFER_EN_IN;
    assign b_read  = ~PORTB_SEL_N_IN & ~PORTB_DIR_WRITE_IN & PORTB_XFER_EN_IN;

    assign fifo_wr     = wr_edge & a_write & ~PORTA_MAIL_SEL_IN & in_full_n_r;
    assign fifo_rd     = rd_edge & b_read & ~PORTB_MAIL_SEL_IN & out_empty_n_r;
    assign mail_in_wr  = wr_edge & a_write & PORTA_MAIL_SEL_IN & mail_in_flag_n_r;
    assign mail_out_wr = rd_edge & b_write & PORTB_MAIL_SEL_IN & mail_out_flag_n_r;

    assign wptr_nxt = fifo_wr ? wptr_r + 7'h01 : wptr_r;
    assign rptr_nxt = fifo_rd ? rptr_r + 7'h01 : rptr_r;

    // each side sees the far pointer only after one stage of its own edges
    assign fill_wr_side = wptr_nxt - rptr_at_wr_r;
    assign fill_rd_side = wptr_at_rd_r - rptr_nxt;
    // fill at or above this mark drives near-full low
    assign full_mark = `FIFO_DEPTH - offset_r;

    always @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            wclk_prev_r <= 1'b1;
            rclk_prev_r <= 1'b1;
        end
        else
        begin
            wclk_prev_r <= WRITE_SIDE_CLOCK_IN;
            rclk_prev_r <= READ_SIDE_CLOCK_IN;
        end
    end

    // offset caught on reset release; clocked so no port feeds a reset path
    always @(posedge SYS_CLK_IN)
    begin
        rstn_prev_r <= RESETN_IN;
        if (!RESETN_IN)
            offset_r <= `OFFSET_RST;
        else if (!rstn_prev_r)
        begin
            if (OFFSET_SEL_HI_IN && OFFSET_SEL_LO_IN)
            begin
                offset_r <= `OFFSET_SEL_HH;
            end
            else if (OFFSET_SEL_HI_IN)
            begin
                offset_r <= `OFFSET_SEL_HL;
            end
            else if (OFFSET_SEL_LO_IN)
            begin
                offset_r <= `OFFSET_SEL_LH;
            end
            else
            begin
                offset_r <= `OFFSET_SEL_LL;
            end
        end
    end

    // write side: storage, pointer and the flags tied to the write clock
    always @(posedge SYS_CLK_IN)
    begin
        if (fifo_wr)
            mem[wptr_r[ADDR_W-1:0]] <= PORTA_DATA_IN;
    end

    // write-side next values, taken only on a detected write-clock edge
    always @*
    begin
        full_rel_nxt    = full_rel_r;
        in_full_n_nxt   = in_full_n_r;
        near_full_n_nxt = near_full_n_r;
        if (wr_edge)
        begin
            full_rel_nxt    = {full_rel_r[0], 1'b1};
            // two edges after reset before writes are let in
            in_full_n_nxt   = full_rel_r[0] & (fill_wr_side != `FIFO_DEPTH);
            near_full_n_nxt = (fill_wr_side < full_mark);
        end
    end

    always @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            wptr_r        <= `FIFO_PTR_RST;
            rptr_at_wr_r  <= `FIFO_PTR_RST;
            full_rel_r    <= `FULL_REL_RST;
            in_full_n_r   <= 1'b0;
            near_full_n_r <= 1'b1;
        end
        else if (wr_edge)
        begin
            wptr_r       <= wptr_nxt;
            // a read landing in this very cycle is seen one write edge later
            rptr_at_wr_r <= rptr_r;
            full_rel_r    <= full_rel_nxt;
            in_full_n_r   <= in_full_n_nxt;
            near_full_n_r <= near_full_n_nxt;
        end
    end

    // read-side next values; flags settle only on a detected read-clock edge
    always @*
    begin
        out_reg_nxt      = out_reg_r;
        out_empty_n_nxt  = out_empty_n_r;
        near_empty_n_nxt = near_empty_n_r;
        if (fifo_rd)
        begin
            out_reg_nxt = mem[rptr_r[ADDR_W-1:0]];
        end
        if (rd_edge)
        begin
            out_empty_n_nxt  = (fill_rd_side != `FIFO_PTR_RST);
            near_empty_n_nxt = (fill_rd_side > offset_r);
        end
    end

    // read side: output register, pointer and the flags tied to the read clock
    always @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            rptr_r         <= `FIFO_PTR_RST;
            wptr_at_rd_r   <= `FIFO_PTR_RST;
            out_empty_n_r  <= 1'b0;
            near_empty_n_r <= 1'b0;
            out_reg_r      <= `DATA_RST;
        end
        else if (rd_edge)
        begin
            out_reg_r      <= out_reg_nxt;
            rptr_r         <= rptr_nxt;
            // first edge captures the write pointer, second raises the flag
            wptr_at_rd_r   <= wptr_r;
            out_empty_n_r  <= out_empty_n_nxt;
            near_empty_n_r <= near_empty_n_nxt;
        end
    end

    // mailboxes: a write drops the flag, the far port's read raises it
    // a write wins over a same-edge read only while the flag is high; a write to a full mailbox is dropped
    always @*
    begin
        mail_in_nxt         = mail_in_r;
        mail_out_nxt        = mail_out_r;
        mail_in_flag_n_nxt  = mail_in_flag_n_r;
        mail_out_flag_n_nxt = mail_out_flag_n_r;
        if (mail_in_wr)
        begin
            mail_in_nxt        = PORTA_DATA_IN;
            mail_in_flag_n_nxt = 1'b0;
        end
        else if (rd_edge && b_read && PORTB_MAIL_SEL_IN)
        begin
            mail_in_flag_n_nxt = 1'b1;
        end
        if (mail_out_wr)
        begin
            mail_out_nxt        = PORTB_DATA_IN;
            mail_out_flag_n_nxt = 1'b0;
        end
        else if (wr_edge && a_read && PORTA_MAIL_SEL_IN)
        begin
            mail_out_flag_n_nxt = 1'b1;
        end
    end

    always @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            mail_in_flag_n_r  <= 1'b1;
            mail_out_flag_n_r <= 1'b1;
            mail_in_r         <= `DATA_RST;
            mail_out_r        <= `DATA_RST;
        end
        else
        begin
            mail_in_r         <= mail_in_nxt;
            mail_in_flag_n_r  <= mail_in_flag_n_nxt;
            mail_out_r        <= mail_out_nxt;
            mail_out_flag_n_r <= mail_out_flag_n_nxt;
        end
    end

    assign PORTA_DATA_OUT    = mail_out_r;
    assign PORTA_DATA_OE_OUT = ~PORTA_SEL_N_IN & ~PORTA_DIR_WRITE_IN;
    assign PORTB_DATA_OUT    = PORTB_MAIL_SEL_IN ? mail_in_r : out_reg_r;
    assign PORTB_DATA_OE_OUT = ~PORTB_SEL_N_IN & ~PORTB_DIR_WRITE_IN;

    // trees are busy generating for the mail read, so the check is masked
    assign PORTA_PARITY_ERR_N_OUT = (a_read & PORTA_MAIL_SEL_IN & PORTA_PARITY_GEN_IN) |
                                    ~bus_fails(PORTA_DATA_IN, PARITY_ODD_SEL_IN);
    assign PORTB_PARITY_ERR_N_OUT = (b_read & PORTB_MAIL_SEL_IN & PORTB_PARITY_GEN_IN) |
                                    ~bus_fails(PORTB_DATA_IN, PARITY_ODD_SEL_IN);

    assign IN_FULL_N_OUT       = in_full_n_r;
    assign NEAR_FULL_N_OUT     = near_full_n_r;
    assign OUT_EMPTY_N_OUT     = out_empty_n_r;
    assign NEAR_EMPTY_N_OUT    = near_empty_n_r;
    assign MAIL_IN_FLAG_N_OUT  = mail_in_flag_n_r;
    assign MAIL_OUT_FLAG_N_OUT = mail_out_flag_n_r;

endmodule // fifo_flags_mailbox
`default_nettype wire

/* tb/fifo_flags_properties.sv */
// concurrent checks on the ports of the fifo flag, mailbox and parity block
`timescale 1ns/10ps
`default_nettype none
module fifo_flags_checker #(parameter DATA_W = 36)
(
    input wire logic              SYS_CLK_IN,
    input wire logic              RESETN_IN,
    input wire logic              WRITE_SIDE_CLOCK_IN,
    input wire logic              READ_SIDE_CLOCK_IN,
    input wire logic              PARITY_ODD_SEL_IN,
    input wire logic              PORTA_SEL_N_IN,
    input wire logic              PORTA_DIR_WRITE_IN,
    input wire logic              PORTA_XFER_EN_IN,
    input wire logic              PORTA_MAIL_SEL_IN,
    input wire logic              PORTA_PARITY_GEN_IN,
    input wire logic [DATA_W-1:0] PORTA_DATA_IN,
    input wire logic [DATA_W-1:0] PORTA_DATA_OUT,
    input wire logic              PORTA_PARITY_ERR_N_OUT,
    input wire logic              PORTB_SEL_N_IN,
    input wire logic              PORTB_DIR_WRITE_IN,
    input wire logic              PORTB_XFER_EN_IN,
    input wire logic              PORTB_MAIL_SEL_IN,
    input wire logic [DATA_W-1:0] PORTB_DATA_IN,
    input wire logic [DATA_W-1:0] PORTB_DATA_OUT,
    input wire logic              PORTB_DATA_OE_OUT,
    input wire logic              IN_FULL_N_OUT,
    input wire logic              NEAR_FULL_N_OUT,
    input wire logic              OUT_EMPTY_N_OUT,
    input wire logic              NEAR_EMPTY_N_OUT,
    input wire logic              MAIL_IN_FLAG_N_OUT,
    input wire logic              MAIL_OUT_FLAG_N_OUT
);
    logic a_q;
    logic b_q;
    // held high in reset like the block's own edge detector, so no false edge follows
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            a_q <= 1'b1;
            b_q <= 1'b1;
        end
        else
        begin
            a_q <= WRITE_SIDE_CLOCK_IN;
            b_q <= READ_SIDE_CLOCK_IN;
        end
    end
    wire a_go = WRITE_SIDE_CLOCK_IN & ~a_q & ~PORTA_SEL_N_IN & PORTA_XFER_EN_IN;
    wire b_go = READ_SIDE_CLOCK_IN & ~b_q & ~PORTB_SEL_N_IN & PORTB_XFER_EN_IN;
    wire a_mwr = a_go & PORTA_DIR_WRITE_IN & PORTA_MAIL_SEL_IN;
    wire a_mrd = a_go & ~PORTA_DIR_WRITE_IN & PORTA_MAIL_SEL_IN;
    wire b_mwr = b_go & PORTB_DIR_WRITE_IN & PORTB_MAIL_SEL_IN;
    wire b_mrd = b_go & ~PORTB_DIR_WRITE_IN & PORTB_MAIL_SEL_IN;
    wire b_frd = b_go & ~PORTB_DIR_WRITE_IN & ~PORTB_MAIL_SEL_IN & ~OUT_EMPTY_N_OUT;
    // shared trees: a mail read with generation on masks the check
    wire a_frc = ~PORTA_SEL_N_IN & PORTA_XFER_EN_IN & ~PORTA_DIR_WRITE_IN
                 & PORTA_MAIL_SEL_IN & PORTA_PARITY_GEN_IN;
    wire [3:0] a_bad = {^PORTA_DATA_IN[35:27], ^PORTA_DATA_IN[26:18],
                        ^PORTA_DATA_IN[17:9], ^PORTA_DATA_IN[8:0]} ^ {4{PARITY_ODD_SEL_IN}};
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence mail_in_wr;
        a_mwr && !b_mrd;
    endsequence
    sequence mail_out_wr;
        b_mwr && MAIL_OUT_FLAG_N_OUT;
    endsequence
    full_sync_a: assert property (!(WRITE_SIDE_CLOCK_IN && !a_q)
        |=> $stable({IN_FULL_N_OUT, NEAR_FULL_N_OUT})) else $error("write flags moved off edge");
    empty_sync_a: assert property (!(READ_SIDE_CLOCK_IN && !b_q)
        |=> $stable({OUT_EMPTY_N_OUT, NEAR_EMPTY_N_OUT})) else $error("read flags moved off edge");
    empty_ignore_a: assert property (b_frd |=> $stable(PORTB_DATA_OUT) || PORTB_MAIL_SEL_IN)
        else $error("read taken while empty");
    mail_in_set_a: assert property (mail_in_wr |=> !MAIL_IN_FLAG_N_OUT)
        else $error("inbound mail flag not lowered");
    mail_in_clear_a: assert property (b_mrd && !a_mwr |=> MAIL_IN_FLAG_N_OUT)
        else $error("inbound mail flag not raised");
    mail_out_store_a: assert property (mail_out_wr |=> !MAIL_OUT_FLAG_N_OUT
        && PORTA_DATA_OUT == $past(PORTB_DATA_IN)) else $error("outbound mail not stored");
    mail_out_keep_a: assert property (!(b_mwr && MAIL_OUT_FLAG_N_OUT)
        |=> $stable(PORTA_DATA_OUT)) else $error("outbound mail changed");
    port_b_oe_a: assert property (PORTB_DATA_OE_OUT == (!PORTB_SEL_N_IN && !PORTB_DIR_WRITE_IN))
        else $error("port b drive wrong");
    parity_a_a: assert property (PORTA_PARITY_ERR_N_OUT == (a_frc || a_bad == 4'h0))
        else $error("port a parity flag wrong");
    cover property (a_mrd && !MAIL_OUT_FLAG_N_OUT);
endmodule // fifo_flags_checker
bind fifo_flags_mailbox fifo_flags_checker #(.DATA_W(DATA_W)) chk_i (.*);
`default_nettype wire

/* tb/port_clock_source.sv */
// free-running port clocks for the two bus masters
`timescale 1ns/10ps
`default_nettype none
module port_clock_source
(
    input  wire logic sys_clk_in,
    output wire logic wclk_out,
    output wire logic rclk_out
);
    logic [1:0] a_cnt_r = 2'h0;
    logic [2:0] b_cnt_r = 3'h0;
    // run free so a reset always sees at least five edges of each port clock; kept below half the sampling rate
    always @(posedge sys_clk_in)
    begin
        a_cnt_r <= a_cnt_r + 2'h1;
        b_cnt_r <= (b_cnt_r == 3'h5) ? 3'h0 : b_cnt_r + 3'h1;
    end
    assign wclk_out = a_cnt_r[1];
    assign rclk_out = b_cnt_r > 3'h2;
endmodule // port_clock_source
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the fifo flag, mailbox and parity block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic SYS_CLK_IN = 0, RESETN_IN = 0, OFFSET_SEL_LO_IN = 0, OFFSET_SEL_HI_IN = 0;
    logic PARITY_ODD_SEL_IN = 1, PORTA_SEL_N_IN = 1, PORTA_DIR_WRITE_IN = 0, PORTA_XFER_EN_IN = 0;
    logic PORTA_MAIL_SEL_IN = 0, PORTA_PARITY_GEN_IN = 0, PORTB_SEL_N_IN = 1, PORTB_DIR_WRITE_IN = 0;
    logic PORTB_XFER_EN_IN = 0, PORTB_MAIL_SEL_IN = 0, PORTB_PARITY_GEN_IN = 0, rprev = 0;
    logic [35:0] PORTA_DATA_IN = 36'h0, PORTB_DATA_IN = 36'h0, d;
    wire [35:0] PORTA_DATA_OUT, PORTB_DATA_OUT;
    wire PORTA_DATA_OE_OUT, PORTA_PARITY_ERR_N_OUT, PORTB_DATA_OE_OUT, PORTB_PARITY_ERR_N_OUT;
    wire IN_FULL_N_OUT, NEAR_FULL_N_OUT, OUT_EMPTY_N_OUT, NEAR_EMPTY_N_OUT;
    wire MAIL_IN_FLAG_N_OUT, MAIL_OUT_FLAG_N_OUT, WRITE_SIDE_CLOCK_IN, READ_SIDE_CLOCK_IN;
    int num_errors = 0, samples_checked = 0, cyc = 0, e, i, x;
    always #20 SYS_CLK_IN = ~SYS_CLK_IN;
    always @(posedge SYS_CLK_IN) rprev <= READ_SIDE_CLOCK_IN;
    fifo_flags_mailbox dut (.*);
    port_clock_source far_end (.sys_clk_in(SYS_CLK_IN), .wclk_out(WRITE_SIDE_CLOCK_IN),
                               .rclk_out(READ_SIDE_CLOCK_IN));
    function automatic logic [35:0] word(input int n);
        word = 36'h9A5C3E100 + 36'(n);
    endfunction
    task chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer, held until the chosen port's clock edge has been sampled
    task op(input logic p, w, m, input logic [35:0] v);
        @(posedge SYS_CLK_IN);
        if (p)
        begin
            {PORTB_SEL_N_IN, PORTB_DIR_WRITE_IN, PORTB_XFER_EN_IN, PORTB_MAIL_SEL_IN} <= {1'b0, w, 1'b1, m};
            PORTB_DATA_IN <= v;
            @(posedge READ_SIDE_CLOCK_IN);
        end
        else
        begin
            {PORTA_SEL_N_IN, PORTA_DIR_WRITE_IN, PORTA_XFER_EN_IN, PORTA_MAIL_SEL_IN} <= {1'b0, w, 1'b1, m};
            PORTA_DATA_IN <= v;
            @(posedge WRITE_SIDE_CLOCK_IN);
        end
        @(posedge SYS_CLK_IN);
        PORTA_XFER_EN_IN <= 1'b0;
        PORTB_XFER_EN_IN <= 1'b0;
        #1;
    endtask
    task sync(input logic p);
        repeat (3) if (p) @(posedge READ_SIDE_CLOCK_IN); else @(posedge WRITE_SIDE_CLOCK_IN);
        @(posedge SYS_CLK_IN);
        #1;
    endtask
    task reset_to(input logic [1:0] s);
        @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b0;
        {OFFSET_SEL_HI_IN, OFFSET_SEL_LO_IN} <= s;
        repeat (30) @(posedge SYS_CLK_IN);
        RESETN_IN <= 1'b1;
        #1;
        chk({OUT_EMPTY_N_OUT, NEAR_EMPTY_N_OUT, NEAR_FULL_N_OUT, MAIL_IN_FLAG_N_OUT, MAIL_OUT_FLAG_N_OUT}, 40'h7);
        sync(0);
        chk(IN_FULL_N_OUT, 1'b1);
    endtask
    task near_empty_levels;
        for (x = 0; x < 4; x++)
        begin
            reset_to(x[1:0]);
            for (i = 0; i < 4 * x + 4; i++) op(0, 1, 0, word(i));
            sync(1);
            chk(NEAR_EMPTY_N_OUT, 1'b0);
            op(0, 1, 0, word(i));
            sync(1);
            chk(NEAR_EMPTY_N_OUT, 1'b1);
        end
    endtask
    task empty_timing;
        reset_to(2'h0);
        op(1, 0, 0, 36'h0);
        chk(PORTB_DATA_OUT, 36'h0);
        op(0, 1, 0, word(7));
        e = 0;
        while (e < 2)
        begin
            @(posedge SYS_CLK_IN);
            if (READ_SIDE_CLOCK_IN && !rprev) e++;
            #1;
            chk(OUT_EMPTY_N_OUT, e == 2);
        end
        op(1, 0, 0, 36'h0);
        chk(PORTB_DATA_OUT, word(7));
    endtask
    task fill_and_drain;
        reset_to(2'h0);
        for (i = 0; i < 64; i++) op(0, 1, 0, word(i));
        sync(0);
        chk({IN_FULL_N_OUT, NEAR_FULL_N_OUT}, 40'h0);
        op(0, 1, 0, 36'h0);
        for (i = 0; i < 64; i++)
        begin
            op(1, 0, 0, 36'h0);
            chk(PORTB_DATA_OUT, word(i));
            if (i == 0 || i == 3 || i == 4)
            begin
                sync(0);
                chk({IN_FULL_N_OUT, NEAR_FULL_N_OUT}, {1'b1, i == 4});
            end
        end
        sync(1);
        chk(OUT_EMPTY_N_OUT, 1'b0);
    endtask
    task mailboxes;
        op(0, 1, 1, 36'hC3A5F0123);
        op(0, 1, 1, 36'h0);
        chk(MAIL_IN_FLAG_N_OUT, 1'b0);
        op(1, 0, 1, 36'h0);
        chk({MAIL_IN_FLAG_N_OUT, PORTB_DATA_OUT}, {1'b1, 36'hC3A5F0123});
        op(1, 1, 1, 36'h5A5A5A5A5);
        chk({MAIL_OUT_FLAG_N_OUT, PORTA_DATA_OE_OUT, PORTA_DATA_OUT}, {2'h0, 36'h5A5A5A5A5});
        op(0, 0, 1, 36'h0);
        chk({MAIL_OUT_FLAG_N_OUT, PORTA_DATA_OE_OUT, PORTA_DATA_OUT}, {2'h3, 36'h5A5A5A5A5});
    endtask
    task parity;
        for (i = 0; i < 6; i++)
        begin
            d = (i < 2) ? 36'hFFFFFFFFF : (i < 4) ? 36'h0 : 36'h7FFFFFFFF;
            @(posedge SYS_CLK_IN);
            PARITY_ODD_SEL_IN <= i[0];
            PORTA_DATA_IN <= d;
            PORTB_DATA_IN <= d;
            @(negedge SYS_CLK_IN);
            chk({PORTA_PARITY_ERR_N_OUT, PORTB_PARITY_ERR_N_OUT}, {2{i == 1 || i == 2}});
        end
        @(posedge SYS_CLK_IN);
        {PORTA_XFER_EN_IN, PORTA_PARITY_GEN_IN} <= 2'h3;
        @(negedge SYS_CLK_IN);
        chk({PORTA_PARITY_ERR_N_OUT, PORTB_PARITY_ERR_N_OUT}, 40'h2);
        @(posedge SYS_CLK_IN);
        {PORTA_XFER_EN_IN, PORTA_PARITY_GEN_IN} <= 2'h0;
    endtask
    task tally_and_finish;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        near_empty_levels();
        empty_timing();
        fill_and_drain();
        mailboxes();
        parity();
        tally_and_finish();
    end
    always @(posedge SYS_CLK_IN)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
endmodule // tb_top
`default_nettype wire
